// ===== wake_input_and_interrupt_logic.sv
// ===========================================================================
// wake input, wake status latching and interrupt signalling
// ===========================================================================
// holds status flags, pull control, converter select and wake requests
// assumes the chip mode machine and event sources sit outside
`timescale 1ns/1ps

// What this block does
// - both pin edges count as wake events
// - filtered edge in normal/stop raises interrupt
// - enabled pin edge wakes device from sleep
// - fail-safe: any edge requests restart, ignoring enable
// - pin event sets pin wake flag
// - pin level readable in normal/stop
// - stop mode: pin level selects pfm/pwm
// - converter select follows pin unfiltered
// - converter select still allows sleep wake
// - pull field: none, pull-down, pull-up
// - pull field 11 follows pin level
// - interrupt is fixed low pulse in normal/stop
// - minimum high time between interrupt pulses
// - interrupt never changes chip mode
// - interrupt sources: wake, can, battery, auto-pwm
// - wake interrupts only for enabled sources
// - level status never interrupts, never latched
// - stop entry with status set interrupts
// - visible status updates at interrupt fall
// - flags stay latched until cleared
module wake_input_and_interrupt_logic
  import wake_int_pkg::*;
#(
  parameter int unsigned INT_PULSE_CYCLES = INT_PULSE_CYCLES_DEF,
  parameter int unsigned INT_GAP_CYCLES   = INT_GAP_CYCLES_DEF
) (
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              wake_pin_i,
  input  chip_mode_e             chip_mode_i,
  input  pin_cfg_s               pin_cfg_i,
  input  wire logic              battery_wake_enable_i,
  input  wire logic              battery_sense_event_i,
  input  wire logic [CAN_CHANNELS-1:0] can_timeout_event_i,
  input  wire logic [CAN_CHANNELS-1:0] can_timeout_mask_i,
  input  wire logic              auto_pwm_event_i,
  input  wake_status_s           status_clear_i,
  output logic                   int_n_o,
  output wake_status_s           wake_status_o,
  output logic                   pin_level_status_o,
  output logic                   sleep_wake_request_o,
  output logic                   restart_request_o,
  output logic                   buck_mode_by_pin_o,
  output logic                   buck_pwm_select_o,
  output logic                   pull_up_enable_o,
  output logic                   pull_down_enable_o
);

  // =========================================================================
  // state
  // =========================================================================
  typedef struct packed {
    wake_status_s live;
    wake_status_s shown;
    chip_mode_e   prev_mode;
    logic         mode_valid;
    logic         level_stat;
    logic         sleep_wake;
    logic         restart;
    logic         by_pin;
    logic         pwm_sel;
    logic         pull_up;
    logic         pull_down;
  } top_state_s;

  localparam logic [INT_CNT_W-1:0] PULSE_LAST =
    INT_CNT_W'(INT_PULSE_CYCLES - 1);
  localparam logic [INT_CNT_W-1:0] GAP_LAST =
    INT_CNT_W'(INT_GAP_CYCLES - 1);

  top_state_s   st_reg;
  top_state_s   st_next;
  logic         raw_level;
  logic         filt_level;
  logic         filt_edge;
  logic         int_fall;
  logic         int_req;
  wake_status_s set_bits;
  wake_status_s new_bits;
  logic         int_mode;
  logic         stop_entry;

  function automatic logic is_int_mode(input chip_mode_e m);
    return (m == MODE_NORMAL) || (m == MODE_STOP);
  endfunction : is_int_mode

  // =========================================================================
  // submodules
  // =========================================================================
  wake_pin_filter u_filter (
    .core_clk_i   (core_clk_i),
    .arst_n_i     (arst_n_i),
    .wake_pin_i   (wake_pin_i),
    .raw_level_o  (raw_level),
    .filt_level_o (filt_level),
    .filt_edge_o  (filt_edge)
  );

  int_pulse_gen #(
    .PULSE_LAST (PULSE_LAST),
    .GAP_LAST   (GAP_LAST)
  ) u_pulse (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .req_i      (int_req),
    .int_n_o    (int_n_o),
    .fall_o     (int_fall)
  );

  // =========================================================================
  // event capture
  // =========================================================================
  always_comb begin
    set_bits = '0;
    int_mode = is_int_mode(chip_mode_i);
    // fail-safe makes the pin a wake source regardless of its enable
    if (filt_edge && (pin_cfg_i.wake_pin_enable ||
        chip_mode_i == MODE_FAIL_SAFE)) begin
      set_bits.first[FIRST_PIN_BIT] = 1'b1;
    end
    if (battery_sense_event_i && battery_wake_enable_i) begin
      set_bits.first[FIRST_BAT_BIT] = 1'b1;
    end
    if (auto_pwm_event_i && chip_mode_i == MODE_STOP) begin
      set_bits.first[FIRST_PWM_BIT] = 1'b1;
    end
    set_bits.third[THIRD_CAN_LSB +: CAN_CHANNELS] =
      can_timeout_event_i;
  end

  // only bits that turn on now may ask for an interrupt; masked can
  // channels still latch but stay quiet
  always_comb begin
    new_bits = set_bits & ~st_reg.live;
    new_bits.third[THIRD_CAN_LSB +: CAN_CHANNELS] =
      new_bits.third[THIRD_CAN_LSB +: CAN_CHANNELS] &
      ~can_timeout_mask_i;
  end

  // the filtered pin edge reaches the interrupt through its flag only
  assign stop_entry = st_reg.mode_valid && chip_mode_i == MODE_STOP &&
                      st_reg.prev_mode != MODE_STOP &&
                      (|st_reg.live.first || |st_reg.live.third);
  // level status feeds nothing here, so it can never interrupt
  assign int_req = int_mode && (|new_bits.first || |new_bits.third ||
                                stop_entry);

  // =========================================================================
  // next state
  // =========================================================================
  always_comb begin
    st_next            = st_reg;
    st_next.prev_mode  = chip_mode_i;
    st_next.mode_valid = 1'b1;
    // set wins over a clear arriving in the same cycle
    st_next.live.first = (st_reg.live.first & ~status_clear_i.first) |
                         set_bits.first;
    st_next.live.third = (st_reg.live.third & ~status_clear_i.third) |
                         set_bits.third;
    if (int_fall) begin
      st_next.shown = st_next.live;
    end else begin
      st_next.shown.first = st_reg.shown.first & ~status_clear_i.first;
      st_next.shown.third = st_reg.shown.third & ~status_clear_i.third;
    end

    // plain unlatched level, valid only while the mode allows reading
    st_next.level_stat = int_mode ? raw_level : 1'b0;

    // wake requests only; the pulse path never touches the mode
    st_next.sleep_wake = filt_edge && chip_mode_i == MODE_SLEEP &&
                         pin_cfg_i.wake_pin_enable;
    st_next.restart    = filt_edge &&
                         chip_mode_i == MODE_FAIL_SAFE;

    // converter select follows the settled pin without the wake filter
    st_next.by_pin  = pin_cfg_i.converter_select_by_pin &&
                      chip_mode_i == MODE_STOP;
    st_next.pwm_sel = st_next.by_pin && raw_level;

    case (pin_cfg_i.pull_select_control)
      PULL_NONE: begin
        st_next.pull_up   = 1'b0;
        st_next.pull_down = 1'b0;
      end
      PULL_DOWN: begin
        st_next.pull_up   = 1'b0;
        st_next.pull_down = 1'b1;
      end
      PULL_UP: begin
        st_next.pull_up   = 1'b1;
        st_next.pull_down = 1'b0;
      end
      PULL_AUTO: begin
        // keeper: reinforces whatever level the pin sits at
        st_next.pull_up   = raw_level;
        st_next.pull_down = ~raw_level;
      end
      default: begin
        st_next.pull_up   = 1'b0;
        st_next.pull_down = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // =========================================================================
  // outputs
  // =========================================================================
  assign wake_status_o        = st_reg.shown;
  assign pin_level_status_o   = st_reg.level_stat;
  assign sleep_wake_request_o = st_reg.sleep_wake;
  assign restart_request_o    = st_reg.restart;
  assign buck_mode_by_pin_o   = st_reg.by_pin;
  assign buck_pwm_select_o    = st_reg.pwm_sel;
  assign pull_up_enable_o     = st_reg.pull_up;
  assign pull_down_enable_o   = st_reg.pull_down;

endmodule : wake_input_and_interrupt_logic

// ===== wake_int_pkg.sv
// ===========================================================================
// shared types and constants for the wake input and interrupt logic
// ===========================================================================
// assumes one 100 MHz core clock; chip mode and event sources are outside
package wake_int_pkg;

  // =========================================================================
  // timing
  // =========================================================================
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WAKE_FILTER_NS = 16000;
  // least time: round up to whole cycles
  localparam int unsigned WAKE_FILTER_CYCLES =
    (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INT_PULSE_NS = 100000;
  localparam int unsigned INT_GAP_NS = 100000;
  localparam int unsigned INT_PULSE_CYCLES_DEF =
    (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INT_GAP_CYCLES_DEF =
    (INT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_CNT_W = 11;
  localparam int unsigned INT_CNT_W = 14;

  // =========================================================================
  // pull selection codes
  // =========================================================================
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;

  // =========================================================================
  // status layout
  // =========================================================================
  localparam int unsigned CAN_CHANNELS = 4;
  localparam int unsigned STAT_W = 8;
  localparam int unsigned FIRST_PIN_BIT = 0;
  localparam int unsigned FIRST_BAT_BIT = 1;
  localparam int unsigned FIRST_PWM_BIT = 2;
  localparam int unsigned THIRD_CAN_LSB = 0;
  localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_FAIL_SAFE,
    MODE_RESTART,
    MODE_OTHER
  } chip_mode_e;

  typedef struct packed {
    logic [STAT_W-1:0] first;
    logic [STAT_W-1:0] third;
  } wake_status_s;

  typedef struct packed {
    logic       wake_pin_enable;
    logic       converter_select_by_pin;
    logic [1:0] pull_select_control;
  } pin_cfg_s;

endpackage : wake_int_pkg

// ===== wake_pin_filter.sv
// ===========================================================================
// wake pin synchroniser and level-change filter
// ===========================================================================
// assumes wake_pin_i is asynchronous to core_clk_i
`timescale 1ns/1ps
module wake_pin_filter
  import wake_int_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  input  wire logic wake_pin_i,
  output logic      raw_level_o,
  output logic      filt_level_o,
  output logic      filt_edge_o
);

  typedef struct packed {
    logic                  s1;
    logic                  s2;
    logic                  s3;
    logic                  primed;
    logic                  raw;
    logic                  level;
    logic                  edge_p;
    logic [FILT_CNT_W-1:0] cnt;
  } filt_state_s;

  localparam logic [FILT_CNT_W-1:0] FILT_LAST =
    FILT_CNT_W'(WAKE_FILTER_CYCLES - 1);

  filt_state_s st_reg;
  filt_state_s st_next;

  always_comb begin
    st_next        = st_reg;
    st_next.s1     = wake_pin_i;
    st_next.s2     = st_reg.s1;
    st_next.s3     = st_reg.s2;
    st_next.edge_p = 1'b0;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.raw = st_reg.s3;
    end
    // first s2/s3 match is taken as the level; both reset low, so a pin high out of reset gives an edge
    if (!st_reg.primed) begin
      if (st_reg.s2 == st_reg.s3) begin
        st_next.primed = 1'b1;
        st_next.level  = st_reg.s3;
      end
    end else if (st_reg.raw != st_reg.level) begin
      if (st_reg.cnt == FILT_LAST) begin
        st_next.level  = st_reg.raw;
        st_next.edge_p = 1'b1;
        st_next.cnt    = '0;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end else begin
      // a glitch shorter than the filter restarts the count
      st_next.cnt = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign raw_level_o  = st_reg.raw;
  assign filt_level_o = st_reg.level;
  assign filt_edge_o  = st_reg.edge_p;

endmodule : wake_pin_filter

// ===== int_pulse_gen.sv
// ===========================================================================
// interrupt pulse generator with minimum spacing
// ===========================================================================
// assumes req_i is a same-clock pulse; requests are merged, never queued
`timescale 1ns/1ps
module int_pulse_gen
  import wake_int_pkg::*;
#(
  parameter logic [INT_CNT_W-1:0] PULSE_LAST = INT_CNT_W'(1),
  parameter logic [INT_CNT_W-1:0] GAP_LAST   = INT_CNT_W'(1)
) (
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  input  wire logic req_i,
  output logic      int_n_o,
  output logic      fall_o
);

  typedef enum logic [1:0] {
    PULSE_IDLE,
    PULSE_LOW,
    PULSE_GAP
  } pulse_state_e;

  typedef struct packed {
    pulse_state_e         state;
    logic [INT_CNT_W-1:0] cnt;
    logic                 pending;
    logic                 int_n;
    logic                 fall;
  } pulse_s;

  pulse_s st_reg;
  pulse_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.fall = 1'b0;
    if (req_i) begin
      st_next.pending = 1'b1;
    end
    case (st_reg.state)
      PULSE_IDLE: begin
        if (req_i || st_reg.pending) begin
          st_next.state   = PULSE_LOW;
          st_next.int_n   = 1'b0;
          st_next.fall    = 1'b1;
          st_next.pending = 1'b0;
          st_next.cnt     = '0;
        end
      end
      PULSE_LOW: begin
        if (st_reg.cnt == PULSE_LAST) begin
          st_next.state = PULSE_GAP;
          st_next.int_n = 1'b1;
          st_next.cnt   = '0;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      PULSE_GAP: begin
        // held high for the spacing time before any further pulse
        if (st_reg.cnt == GAP_LAST) begin
          st_next.state = PULSE_IDLE;
          st_next.cnt   = '0;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      default: begin
        st_next.state = PULSE_IDLE;
        st_next.int_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg       <= '0;
      st_reg.int_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign int_n_o = st_reg.int_n;
  // fall_o marks the edge on which int_n_o drops, so the status copy
  // taken on that edge is the one the reader sees with the pulse
  assign fall_o  = st_next.fall;

endmodule : int_pulse_gen

// ===== wake_int_checker.sv
// port assertions for the wake input and interrupt logic
// assumes one core clock and an asynchronous active-low reset
`timescale 1ns/1ps
module wake_int_checker
  import wake_int_pkg::*;
#(
  parameter int unsigned INT_PULSE_CYCLES = INT_PULSE_CYCLES_DEF,
  parameter int unsigned INT_GAP_CYCLES   = INT_GAP_CYCLES_DEF
) (
  input wire logic   core_clk_i,
  input wire logic   arst_n_i,
  input chip_mode_e  chip_mode_i,
  input pin_cfg_s    pin_cfg_i,
  input wake_status_s status_clear_i,
  input wire logic   int_n_o,
  input wake_status_s wake_status_o,
  input wire logic   pin_level_status_o,
  input wire logic   sleep_wake_request_o,
  input wire logic   restart_request_o,
  input wire logic   buck_mode_by_pin_o,
  input wire logic   buck_pwm_select_o,
  input wire logic   pull_up_enable_o,
  input wire logic   pull_down_enable_o
);
  // ==========================================================================
  // helper counters
  // ==========================================================================
  logic [INT_CNT_W-1:0] low_cnt;
  logic [INT_CNT_W-1:0] high_cnt;
  logic                 stop_sel;
  logic                 clr_any;
  assign stop_sel = chip_mode_i == MODE_STOP
                    && pin_cfg_i.converter_select_by_pin;
  assign clr_any = |status_clear_i;
  // high count starts saturated so the first pulse is never short of gap
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_cnt  <= '0;
      high_cnt <= '1;
    end else begin
      low_cnt  <= int_n_o ? '0 : low_cnt + 1'h1;
      high_cnt <= !int_n_o ? '0 : (&high_cnt ? high_cnt : high_cnt + 1'h1);
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================================
  // properties
  // ==========================================================================
  property p_pulse_width;
    $rose(int_n_o) |-> low_cnt == INT_CNT_W'(INT_PULSE_CYCLES);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width");
  property p_gap;
    $fell(int_n_o) |-> high_cnt >= INT_CNT_W'(INT_GAP_CYCLES);
  endproperty
  a_gap: assert property (p_gap) else $error("pulse spacing");
  property p_int_mode;
    $fell(int_n_o) |-> $past(chip_mode_i) inside {MODE_NORMAL, MODE_STOP};
  endproperty
  a_int_mode: assert property (p_int_mode) else $error("int mode");
  property p_status_hold;
    !$stable(wake_status_o) |-> $fell(int_n_o) || $past(clr_any);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status");
  property p_buck_mode;
    stop_sel |=> buck_mode_by_pin_o;
  endproperty
  a_buck_mode: assert property (p_buck_mode) else $error("buck mode");
  property p_buck_pwm;
    buck_mode_by_pin_o |-> buck_pwm_select_o == pin_level_status_o;
  endproperty
  a_buck_pwm: assert property (p_buck_pwm) else $error("buck pwm");
  property p_pull_none;
    pin_cfg_i.pull_select_control == PULL_NONE [*2]
      |-> !pull_up_enable_o && !pull_down_enable_o;
  endproperty
  a_pull_none: assert property (p_pull_none) else $error("pull none");
  property p_pull_auto;
    pin_cfg_i.pull_select_control == PULL_AUTO [*2]
      |-> pull_up_enable_o != pull_down_enable_o;
  endproperty
  a_pull_auto: assert property (p_pull_auto) else $error("pull auto");
  property p_restart;
    restart_request_o |-> $past(chip_mode_i) == MODE_FAIL_SAFE
      ##1 !restart_request_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart");
  property p_sleep_wake;
    sleep_wake_request_o |-> $past(chip_mode_i) == MODE_SLEEP
      ##1 !sleep_wake_request_o;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake");
  c_int: cover property ($fell(int_n_o));
  c_sleep: cover property (sleep_wake_request_o);
  c_restart: cover property (restart_request_o);
endmodule : wake_int_checker

bind wake_input_and_interrupt_logic wake_int_checker #(
  .INT_PULSE_CYCLES(INT_PULSE_CYCLES),
  .INT_GAP_CYCLES  (INT_GAP_CYCLES)
) u_chk (
  .core_clk_i, .arst_n_i, .chip_mode_i, .pin_cfg_i, .status_clear_i,
  .int_n_o, .wake_status_o, .pin_level_status_o, .sleep_wake_request_o,
  .restart_request_o, .buck_mode_by_pin_o, .buck_pwm_select_o,
  .pull_up_enable_o, .pull_down_enable_o
);

// ===== mcu_model.sv
// microcontroller model: reads the status at each interrupt fall
// assumes the status is settled on the cycle after the fall
`timescale 1ns/1ps
module mcu_model
  import wake_int_pkg::*;
(
  input  wire logic    core_clk_i,
  input  wire logic    arst_n_i,
  input  wire logic    int_n_i,
  input  wake_status_s status_i,
  input  wire logic    clear_en_i,
  output wake_status_s clear_o,
  output wake_status_s seen_o
);
  // ==========================================================================
  // read and clear
  // ==========================================================================
  logic int_n_reg;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_n_reg <= 1'h1;
      clear_o   <= '0;
      seen_o    <= '0;
    end else begin
      int_n_reg <= int_n_i;
      clear_o   <= '0;
      if (int_n_reg && !int_n_i) begin
        seen_o <= status_i;
        // only what was read is cleared, so later flags stay up
        if (clear_en_i) clear_o <= status_i;
      end
    end
  end
endmodule : mcu_model

// ===== tb.sv
// testbench for the wake input and interrupt logic
// assumes short interrupt timing and the mcu model on the far side
`timescale 1ns/1ps
module tb;
  import wake_int_pkg::*;
  typedef struct packed {
    chip_mode_e m;
    logic       c;
    logic [1:0] p;
    logic       w;
    logic [4:0] e;
  } row_s;
  localparam int unsigned PW = 8;
  logic         core_clk_i, arst_n_i, pin, bat_en, bat_ev, auto_ev, clr_en;
  logic         int_n, lvl, swr, rrq, bmode, pwm, pu, pd;
  logic [3:0]   can_ev;
  logic [3:0]   can_mask;
  chip_mode_e   mode;
  pin_cfg_s     cfg;
  wake_status_s stat, clr, seen;
  int           miscompares = 0;
  int           n_tests = 0;
  row_s         rows [8] = '{
    '{MODE_NORMAL, 1'h0, PULL_NONE, 1'h0, 5'h00},
    '{MODE_NORMAL, 1'h0, PULL_DOWN, 1'h0, 5'h01},
    '{MODE_STOP, 1'h1, PULL_UP, 1'h0, 5'h0a},
    '{MODE_STOP, 1'h1, PULL_AUTO, 1'h0, 5'h09},
    '{MODE_STOP, 1'h1, PULL_AUTO, 1'h1, 5'h1e},
    '{MODE_STOP, 1'h0, PULL_DOWN, 1'h1, 5'h11},
    '{MODE_SLEEP, 1'h1, PULL_UP, 1'h1, 5'h02},
    '{MODE_NORMAL, 1'h0, PULL_AUTO, 1'h1, 5'h12}};
  // ==========================================================================
  // design, partner, clock and tasks
  // ==========================================================================
  wake_input_and_interrupt_logic #(
    .INT_PULSE_CYCLES(PW), .INT_GAP_CYCLES(PW)
  ) uut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .wake_pin_i(pin),
    .chip_mode_i(mode), .pin_cfg_i(cfg), .battery_wake_enable_i(bat_en),
    .battery_sense_event_i(bat_ev), .can_timeout_event_i(can_ev),
    .can_timeout_mask_i(can_mask), .auto_pwm_event_i(auto_ev),
    .status_clear_i(clr), .int_n_o(int_n), .wake_status_o(stat),
    .pin_level_status_o(lvl), .sleep_wake_request_o(swr),
    .restart_request_o(rrq), .buck_mode_by_pin_o(bmode),
    .buck_pwm_select_o(pwm), .pull_up_enable_o(pu),
    .pull_down_enable_o(pd));
  mcu_model u_mcu (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .int_n_i(int_n),
    .status_i(stat), .clear_en_i(clr_en), .clear_o(clr), .seen_o(seen));
  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // watches for a fresh int fall (0), sleep wake (1) or restart (2)
  task automatic wait_for(input int idx, input int lim, input logic exp);
    logic [2:0] v;
    logic [2:0] p;
    logic       hit;
    hit = 1'h0;
    p = {rrq, swr, !int_n};
    repeat (lim) begin
      @(posedge core_clk_i);
      #1 v = {rrq, swr, !int_n};
      if (v[idx] && !p[idx]) begin
        hit = 1'h1;
        break;
      end
      p = v;
    end
    chk(16'(hit), 16'(exp));
  endtask : wait_for
  task automatic fire(input logic b, input logic a, input logic [3:0] c);
    @(posedge core_clk_i);
    bat_ev  <= b;
    auto_ev <= a;
    can_ev  <= c;
    @(posedge core_clk_i);
    bat_ev  <= 1'h0;
    auto_ev <= 1'h0;
    can_ev  <= 4'h0;
  endtask : fire
  initial begin
    #300000;
    miscompares++;
    stop_test();
  end
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {arst_n_i, pin, bat_ev, auto_ev, can_ev, can_mask} = '0;
    {bat_en, clr_en} = 2'h3;
    mode = MODE_NORMAL;
    cfg = '{1'h1, 1'h0, PULL_NONE};
    repeat (4) @(posedge core_clk_i);
    #1 chk(16'(int_n), 16'h0001);
    chk(stat, 16'h0000);
    @(posedge core_clk_i) arst_n_i <= 1'h1;
    repeat (4) @(posedge core_clk_i);
    foreach (rows[i]) begin
      @(posedge core_clk_i);
      mode <= rows[i].m;
      cfg.converter_select_by_pin <= rows[i].c;
      cfg.pull_select_control <= rows[i].p;
      pin <= rows[i].w;
      repeat (8) @(posedge core_clk_i);
      #1 chk(16'({lvl, bmode, pwm & bmode, pu, pd}), 16'(rows[i].e));
    end
    wait_for(0, 2000, 1'h1);
    @(posedge core_clk_i) clr_en <= 1'h0;
    #1 chk(seen, 16'h0100);
    fire(1'h1, 1'h0, 4'h2);
    #1 chk(stat, 16'h0000);
    wait_for(0, 30, 1'h1);
    @(posedge core_clk_i) #1 chk(seen, 16'h0202);
    bat_en <= 1'h0;
    can_mask <= 4'h1;
    fire(1'h1, 1'h1, 4'h1);
    wait_for(0, 40, 1'h0);
    chk(stat, 16'h0202);
    @(posedge core_clk_i) mode <= MODE_SLEEP;
    clr_en <= 1'h1;
    repeat (3) @(posedge core_clk_i);
    mode <= MODE_STOP;
    wait_for(0, 10, 1'h1);
    repeat (3) @(posedge core_clk_i);
    #1 chk(stat, 16'h0000);
    fire(1'h0, 1'h1, 4'h0);
    wait_for(0, 30, 1'h1);
    @(posedge core_clk_i) #1 chk(seen, 16'h0400);
    repeat (20) @(posedge core_clk_i);
    mode <= MODE_SLEEP;
    cfg.converter_select_by_pin <= 1'h1;
    pin <= 1'h0;
    wait_for(1, 1700, 1'h1);
    @(posedge core_clk_i) cfg.wake_pin_enable <= 1'h0;
    pin <= 1'h1;
    wait_for(1, 1700, 1'h0);
    @(posedge core_clk_i) mode <= MODE_FAIL_SAFE;
    pin <= 1'h0;
    wait_for(2, 1700, 1'h1);
    @(posedge core_clk_i) mode <= MODE_NORMAL;
    cfg.wake_pin_enable <= 1'h1;
    pin <= 1'h1;
    repeat (100) @(posedge core_clk_i);
    pin <= 1'h0;
    wait_for(0, 1800, 1'h0);
    stop_test();
  end
endmodule : tb
